// ===== logic/rtc_hour_map.svh
`ifndef RTC_HOUR_MAP_SVH
`define RTC_HOUR_MAP_SVH
`define HOUR_COUNT_OFFSET 12'h000
`define WEEKDAY_COUNT_OFFSET 12'h004
`define BUSY_BIT 7
`define HOUR_TENS_HI 5
`define HOUR_TENS_LO 4
`define HOUR_UNITS_HI 3
`define HOUR_UNITS_LO 0
`define WEEKDAY_HI 2
`define WEEKDAY_LO 0
`define HOUR_RESET 6'h00
`define WEEKDAY_RESET 3'h0
`define WEEKDAY_LAST 3'h6
`define WEEKDAY_RESERVED 3'h7
`define UNITS_LAST 4'h9
`define HOUR12_LAST 6'h11
`define HOUR24_LAST 6'h23
`define BUSY_CYCLES 2'h2
`endif

// ===== logic/rtc_hour_pkg.sv
`default_nettype none
package rtc_hour_pkg;
    // bcd hour held as two digits
    typedef struct packed {
        logic [1:0] tens;
        logic [3:0] units;
    } bcd_hour_t;
    // apb request fields travelling together
    typedef struct packed {
        logic [11:0] addr;
        logic write;
        logic [31:0] wdata;
    } apb_req_t;
    // update sequencing
    typedef enum logic [1:0] {
        IDLE,
        UPDATE
    } upd_state_t;
endpackage : rtc_hour_pkg
`default_nettype wire

// ===== logic/rtc_hour_weekday_counters.sv
// Added by the designer: the placing of the registers and the APB slave port.
`include "rtc_hour_map.svh"
`default_nettype none
module rtc_hour_weekday_counters (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // clock chain
    input wire logic hour_carry_in,
    input wire logic mode_24h,
    input wire logic busy_in,
    output logic day_carry_out,
    output logic update_in_progress
);
    import rtc_hour_pkg::*;

    bcd_hour_t hour_r;
    bcd_hour_t hour_nxt;
    logic [2:0] weekday_r;
    logic [2:0] weekday_nxt;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic pready_r;
    logic day_carry_r;
    // afternoon half of the twelve-hour day; only its end passes a daily carry
    logic pm_r;
    logic busy_r;
    logic [1:0] busy_cnt_r;
    upd_state_t state_r;
    apb_req_t req;

    // request bundle
    assign req = '{addr: paddr, write: pwrite, wdata: pwdata};

    // address decode; a write lands in the setup cycle's follow-on access
    wire access = psel && penable && !pready_r;
    wire sel_hour = req.addr == `HOUR_COUNT_OFFSET;
    wire sel_week = req.addr == `WEEKDAY_COUNT_OFFSET;
    wire mapped = sel_hour || sel_week;
    wire wr_hour = access && req.write && sel_hour && pstrb[0];
    wire wr_week = access && req.write && sel_week && pstrb[0];

    // tick decode
    wire units_wrap = hour_r.units == `UNITS_LAST;
    wire [5:0] hour_flat = {hour_r.tens, hour_r.units};
    wire [5:0] hour_last = mode_24h ? `HOUR24_LAST : `HOUR12_LAST;
    wire at_limit = hour_flat == hour_last;
    // daily carry: every 23->00, but only the pm->am 11->00 in twelve-hour mode
    wire day_tick = hour_carry_in && at_limit && (mode_24h || pm_r);
    // half-day toggles on each twelve-hour wrap; a software hour write holds it
    wire pm_flip = hour_carry_in && at_limit && !mode_24h && !wr_hour;
    wire pm_nxt = pm_r ^ pm_flip;

    // bcd hour increment with units carry into tens
    wire [3:0] units_inc = hour_r.units + 4'h1;
    wire [1:0] tens_inc = hour_r.tens + 2'h1;
    bcd_hour_t hour_tick;
    // wrap to 00 at the limit
    assign hour_tick = at_limit ? bcd_hour_t'(`HOUR_RESET) :
        (units_wrap ? bcd_hour_t'({tens_inc, 4'h0}) : bcd_hour_t'({hour_r.tens, units_inc}));

    // binary weekday steps, saturday wraps to sunday
    wire [2:0] week_inc = weekday_r + 3'h1;
    wire [2:0] week_tick = (weekday_r >= `WEEKDAY_LAST) ? `WEEKDAY_RESET : week_inc;

    // written tens digit kept in bits 5..4; software write beats a tick
    assign hour_nxt = wr_hour ?
        bcd_hour_t'(req.wdata[`HOUR_TENS_HI:`HOUR_UNITS_LO]) :
        (hour_carry_in ? hour_tick : hour_r);
    // a written 111 is stored as written; the next daily carry clears it
    assign weekday_nxt = wr_week ? req.wdata[`WEEKDAY_HI:`WEEKDAY_LO] :
        (day_tick ? week_tick : weekday_r);

    // read data with busy flag and zero reserved bits
    wire busy_now = busy_r || busy_in;
    wire [31:0] rd_hour = {24'h0, busy_now, 1'b0, hour_r.tens, hour_r.units};
    wire [31:0] rd_week = {24'h0, busy_now, 4'h0, weekday_r};
    wire [31:0] rd_mux = sel_hour ? rd_hour : (sel_week ? rd_week : 32'h0);

    // counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hour_r <= bcd_hour_t'(`HOUR_RESET);
            weekday_r <= `WEEKDAY_RESET;
            pm_r <= 1'b0;
        end else begin
            hour_r <= hour_nxt;
            weekday_r <= weekday_nxt;
            pm_r <= pm_nxt;
        end
    end

    // busy window: held a few cycles after each hourly carry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= IDLE;
            busy_cnt_r <= 2'h0;
            busy_r <= 1'b0;
        end else begin
            case (state_r)
                IDLE: begin
                    if (hour_carry_in) begin
                        state_r <= UPDATE;
                        busy_cnt_r <= `BUSY_CYCLES;
                        busy_r <= 1'b1;
                    end
                end
                UPDATE: begin
                    if (busy_cnt_r == 2'h1) begin
                        state_r <= IDLE;
                        busy_r <= 1'b0;
                    end
                    busy_cnt_r <= busy_cnt_r - 2'h1;
                end
                default: begin
                    state_r <= IDLE;
                    busy_r <= 1'b0;
                end
            endcase
        end
    end

    // apb answer: one wait state, pready pulses in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0;
            pslverr_r <= 1'b0;
            day_carry_r <= 1'b0;
        end else begin
            pready_r <= access;
            prdata_r <= (access && !req.write) ? rd_mux : 32'h0;
            pslverr_r <= access && !mapped;
            day_carry_r <= day_tick;
        end
    end

    // flag shown to the chain as well
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            update_in_progress <= 1'b0;
        end else begin
            update_in_progress <= busy_r || hour_carry_in || busy_in;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign day_carry_out = day_carry_r;
endmodule : rtc_hour_weekday_counters
`default_nettype wire

// ===== test/rtc_hour_checker_properties.sv
`default_nettype none
module rtc_hour_checker (
    // bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // chain
    input wire logic hour_carry_in,
    input wire logic busy_in,
    input wire logic day_carry_out,
    input wire logic update_in_progress
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // read answers per register
    wire logic rd_hr = pready && !pwrite && paddr == 12'h000;
    wire logic rd_wk = pready && !pwrite && paddr == 12'h004;
    AST_DAY_CAUSE: assert property (day_carry_out |-> $past(hour_carry_in))
        else $error("day carry without hour carry");
    AST_DAY_PULSE: assert property (day_carry_out |=> !day_carry_out)
        else $error("day carry too long");
    AST_BUSY_CARRY: assert property (hour_carry_in |=> update_in_progress[*2])
        else $error("busy short after carry");
    AST_BUSY_IN: assert property (busy_in |=> update_in_progress)
        else $error("busy input lost");
    AST_DAY_BUSY: assert property (day_carry_out |-> update_in_progress)
        else $error("day carry while not busy");
    AST_HR_RSV: assert property (rd_hr |-> prdata[31:8] == 24'h0 && !prdata[6])
        else $error("hour reserved bits set");
    AST_WK_RSV: assert property (rd_wk |-> prdata[31:8] == 24'h0 && prdata[6:3] == 4'h0)
        else $error("weekday reserved bits set");
    AST_HR_TENS: assert property (rd_hr |-> prdata[5:4] != 2'h3)
        else $error("hour tens out of range");
    cover property (day_carry_out);
    cover property (pready && pslverr);
    cover property (rd_wk && prdata[7]);
endmodule : rtc_hour_checker
`default_nettype wire

// ===== test/minute_stage_model.sv
`default_nettype none
module minute_stage_model (
    input wire logic pclk,
    output logic carry
);
    timeunit 1ns;
    timeprecision 1ns;
    initial carry = 1'b0;
    task tick();
        @(posedge pclk);
        carry <= 1'b1;
        @(posedge pclk);
        carry <= 1'b0;
    endtask : tick
endmodule : minute_stage_model
`default_nettype wire

// ===== test/test_rtc_hour_weekday_counters.sv
`default_nettype none
module test_rtc_hour_weekday_counters;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mode_24h = 0, busy_in = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, day_carry_out, update_in_progress, carry, er;
    logic [7:0] rd;
    int n_mismatch = 0, total_checks = 0;
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("Error %0t got %h want %h", $time, a, b); end end
    rtc_hour_weekday_counters uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .hour_carry_in(carry),
        .mode_24h(mode_24h), .busy_in(busy_in), .day_carry_out(day_carry_out),
        .update_in_progress(update_in_progress));
    minute_stage_model mdl (.pclk(pclk), .carry(carry));
    // free-running bus clock
    always #50 pclk = ~pclk;
    task give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata[7:0];
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic tick_chk(input logic ed);
        mdl.tick();
        #1 `CHK(day_carry_out, ed)
        `CHK(update_in_progress, 1'b1)
    endtask : tick_chk
    task t_reset();
        apb(0, 12'h004, 8'h0);
        `CHK(rd, 8'h00)
    endtask : t_reset
    task t_units();
        mode_24h <= 1'b1;
        apb(1, 12'h000, 8'h09);
        tick_chk(0);
        apb(0, 12'h000, 8'h0);
        `CHK(rd, 8'h10)
    endtask : t_units
    task t_wrap24();
        // only codes 0..6 are ever written
        apb(1, 12'h004, 8'h06);
        apb(1, 12'h000, 8'h23);
        tick_chk(1);
        apb(0, 12'h000, 8'h0);
        `CHK(rd, 8'h00)
        apb(0, 12'h004, 8'h0);
        `CHK(rd, 8'h00)
    endtask : t_wrap24
    task t_wrap12();
        mode_24h <= 1'b0;
        apb(1, 12'h000, 8'h11);
        tick_chk(0);
        apb(1, 12'h000, 8'h11);
        tick_chk(1);
        apb(0, 12'h000, 8'h0);
        `CHK(rd, 8'h00)
        apb(0, 12'h004, 8'h0);
        `CHK(rd, 8'h01)
    endtask : t_wrap12
    task t_busy();
        busy_in <= 1'b1;
        apb(0, 12'h004, 8'h0);
        `CHK(rd, 8'h81)
        busy_in <= 1'b0;
        apb(0, 12'h004, 8'h0);
        `CHK(rd, 8'h01)
        apb(1, 12'h000, 8'hc5);
        apb(0, 12'h000, 8'h0);
        `CHK(rd, 8'h05)
        apb(0, 12'h008, 8'h0);
        `CHK({er, rd}, 9'h100)
    endtask : t_busy
    // reset then scenarios
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_units();
        t_wrap24();
        t_wrap12();
        t_busy();
        give_verdict();
    end
    // hang guard, about ten times the run
    initial begin
        #100000;
        n_mismatch++;
        give_verdict();
    end
endmodule : test_rtc_hour_weekday_counters
bind rtc_hour_weekday_counters rtc_hour_checker chk (.pclk(pclk), .presetn(presetn),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hour_carry_in(hour_carry_in), .busy_in(busy_in), .day_carry_out(day_carry_out),
    .update_in_progress(update_in_progress));
`default_nettype wire
